// ===== port_zero_pkg.sv
// Constants shared by the eight-pin general-purpose port.
package port_zero_pkg;

    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] OFF_DATA     = 8'h00;
    localparam logic [7:0] OFF_DIR      = 8'h04;
    localparam logic [7:0] OFF_PULL     = 8'h08;
    localparam logic [7:0] OFF_AIDR     = 8'h0c;
    localparam logic [7:0] OFF_DATA_RMW = 8'h10;
    localparam logic [7:0] OFF_STBY     = 8'h14;
    localparam logic [7:0] OFF_CMPA     = 8'h18;
    localparam logic [7:0] OFF_CMPB     = 8'h1c;

    // Reset values.
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_DIR  = 8'h00;
    localparam logic [7:0] RST_PULL = 8'h00;
    localparam logic [7:0] RST_AIDR = 8'h00;
    localparam logic       RST_STBY = 1'h0;
    localparam logic [1:0] RST_CMP  = 2'h0;

    // Field positions.
    localparam int STBY_PIN_STATE_BIT = 0;
    localparam int CMP_INPUT_OFF_BIT  = 0;
    localparam int CMP_NEG_SEL_BIT    = 1;

    // Pins that carry comparator inputs.
    localparam int CMP0_P_PIN = 0;
    localparam int CMP0_N_PIN = 1;
    localparam int CMP1_P_PIN = 3;
    localparam int CMP1_N_PIN = 4;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== port_zero_gpio.sv
// Eight-pin general-purpose I/O port with an AXI4-Lite register slave.
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Direction bit 1 makes the pin an output driven by its latch bit.
// - Data writes update the latch; output pins follow the new value.
// - Data reads of output pins return the latch contents.
// - Direction bit 0 makes the pin an input and stops driving it.
// - Data writes to input pins still update the latch but do not drive.
// - Input pins read the sampled level; RMW reads return the latch.
// - A peripheral output enable lets the peripheral drive the pin.
// - Peripheral-driven pins read the pin level; RMW reads return the latch.
// - Reset clears all direction bits, making every pin an input.
// - Reset clears analog-input-disable bits, blocking digital input.
// - Standby with pin-state bit set floats pins and clamps inputs low.
// - During isolation, pins with external interrupt enabled keep input.
// - Standby with pin-state bit clear leaves pins unchanged.
// - Pin levels feed the external interrupt circuit, except isolated pins without interrupt enable.
// - Pull-up bit 1 connects the internal pull-up.
// - Pull-up is disconnected whenever the pin is driven as an output at low level.
// - Positive comparator input enabled when analog-enable bit is 0.
// - Negative comparator input enabled only when both control bits are 0.
// - Bit n of each port register controls pin n.
module port_zero_gpio #(
    parameter int PINS = 8
) (
    input  wire logic            aclk,
    input  wire logic            aresetn,
    input  wire logic [7:0]      awaddr,
    input  wire logic            awvalid,
    output logic                 awready,
    input  wire logic [31:0]     wdata,
    input  wire logic [3:0]      wstrb,
    input  wire logic            wvalid,
    output logic                 wready,
    output logic [1:0]           bresp,
    output logic                 bvalid,
    input  wire logic            bready,
    input  wire logic [7:0]      araddr,
    input  wire logic            arvalid,
    output logic                 arready,
    output logic [31:0]          rdata,
    output logic [1:0]           rresp,
    output logic                 rvalid,
    input  wire logic            rready,
    input  wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0]      pin_out,
    output logic [PINS-1:0]      pin_oe,
    output logic [PINS-1:0]      pin_pullup,
    input  wire logic [PINS-1:0] periph_oe,
    input  wire logic [PINS-1:0] periph_out,
    input  wire logic            standby_mode,
    input  wire logic [PINS-1:0] ext_irq_enable,
    output logic [PINS-1:0]      ext_irq_level,
    output logic [PINS-1:0]      port_digital_in,
    output logic [PINS-1:0]      analog_path_en,
    output logic [1:0]           cmp_p_en,
    output logic [1:0]           cmp_n_en
);

    logic [PINS-1:0] port_data_latch;
    logic [PINS-1:0] port_direction;
    logic [PINS-1:0] port_pullup_enable;
    logic [PINS-1:0] analog_input_disable_low;
    logic            standby_pin_state_bit;
    logic [1:0]      comparator_control_a;
    logic [1:0]      comparator_control_b;

    ////////////////////////////////////////////////////////////////////////////
    // Pin input synchroniser; a change counts once the last two stages agree.

    logic [PINS-1:0] sync_a;
    logic [PINS-1:0] sync_b;
    logic [PINS-1:0] sync_c;
    logic [PINS-1:0] pin_level;
    logic [PINS-1:0] agree;
    logic [PINS-1:0] next_pin_level;

    assign agree          = ~(sync_b ^ sync_c);
    assign next_pin_level = (agree & sync_c) | (~agree & pin_level);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a    <= '0;
            sync_b    <= '0;
            sync_c    <= '0;
            pin_level <= '0;
        end else begin
            sync_a    <= pin_in;
            sync_b    <= sync_a;
            sync_c    <= sync_b;
            pin_level <= next_pin_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input gating, standby isolation and peripheral feeds.

    logic            iso;
    logic [PINS-1:0] clamp;

    // Isolation needs both the standby state and the pin-state bit.
    assign iso             = standby_mode && standby_pin_state_bit;
    assign clamp           = {PINS{iso}} & ~ext_irq_enable;
    assign ext_irq_level   = pin_level & ~clamp;
    assign port_digital_in = pin_level & analog_input_disable_low & ~clamp;
    assign analog_path_en  = ~analog_input_disable_low;
    assign cmp_p_en[0] = !comparator_control_a[port_zero_pkg::CMP_INPUT_OFF_BIT];
    assign cmp_p_en[1] = !comparator_control_b[port_zero_pkg::CMP_INPUT_OFF_BIT];
    assign cmp_n_en[0] = !comparator_control_a[port_zero_pkg::CMP_INPUT_OFF_BIT]
                      && !comparator_control_a[port_zero_pkg::CMP_NEG_SEL_BIT];
    assign cmp_n_en[1] = !comparator_control_b[port_zero_pkg::CMP_INPUT_OFF_BIT]
                      && !comparator_control_b[port_zero_pkg::CMP_NEG_SEL_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive, registered so the pad sees glitch-free enables.

    logic [PINS-1:0] next_pin_oe;
    logic [PINS-1:0] next_pin_out;
    logic [PINS-1:0] next_pin_pullup;

    assign next_pin_oe     = (port_direction | periph_oe) & ~{PINS{iso}};
    assign next_pin_out    = (periph_oe & periph_out)
                           | (~periph_oe & port_data_latch);
    assign next_pin_pullup = port_pullup_enable & ~(next_pin_oe & ~next_pin_out);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out    <= '0;
            pin_oe     <= '0;
            pin_pullup <= '0;
        end else begin
            pin_out    <= next_pin_out;
            pin_oe     <= next_pin_oe;
            pin_pullup <= next_pin_pullup;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel; address and data are taken in either order.

    logic            aw_held;
    logic [7:0]      aw_addr;
    logic            w_held;
    logic [PINS-1:0] w_data;
    logic            w_lane0;
    logic            aw_fire;
    logic            w_fire;
    logic            wr_fire;
    logic            wr_ok;
    logic            wr_sel_data;
    logic            wr_sel_dir;
    logic            wr_sel_pull;
    logic            wr_sel_aidr;
    logic            wr_sel_stby;
    logic            wr_sel_cmpa;
    logic            wr_sel_cmpb;
    logic            wr_hit;

    assign awready = !aw_held && !bvalid;
    assign wready  = !w_held && !bvalid;
    assign aw_fire = awvalid && awready;
    assign w_fire  = wvalid && wready;
    assign wr_fire = aw_held && w_held && !bvalid;
    assign wr_ok   = wr_fire && w_lane0;

    // The RMW offset is an alias of the latch for writes.
    assign wr_sel_data = (aw_addr == port_zero_pkg::OFF_DATA)
                      || (aw_addr == port_zero_pkg::OFF_DATA_RMW);
    assign wr_sel_dir  = (aw_addr == port_zero_pkg::OFF_DIR);
    assign wr_sel_pull = (aw_addr == port_zero_pkg::OFF_PULL);
    assign wr_sel_aidr = (aw_addr == port_zero_pkg::OFF_AIDR);
    assign wr_sel_stby = (aw_addr == port_zero_pkg::OFF_STBY);
    assign wr_sel_cmpa = (aw_addr == port_zero_pkg::OFF_CMPA);
    assign wr_sel_cmpb = (aw_addr == port_zero_pkg::OFF_CMPB);
    assign wr_hit      = wr_sel_data || wr_sel_dir || wr_sel_pull || wr_sel_aidr
                      || wr_sel_stby || wr_sel_cmpa || wr_sel_cmpb;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (aw_fire) begin
            aw_held <= 1'b1;
            aw_addr <= awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held  <= 1'b0;
            w_data  <= '0;
            w_lane0 <= 1'b0;
        end else if (w_fire) begin
            w_held  <= 1'b1;
            w_data  <= wdata[PINS-1:0];
            w_lane0 <= wstrb[0];
        end else if (wr_fire) begin
            w_held  <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= port_zero_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= wr_hit ? port_zero_pkg::RESP_OKAY : port_zero_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file; a write takes effect at the edge after both halves are held.

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_data_latch          <= port_zero_pkg::RST_DATA;
            port_direction           <= port_zero_pkg::RST_DIR;
            port_pullup_enable       <= port_zero_pkg::RST_PULL;
            analog_input_disable_low <= port_zero_pkg::RST_AIDR;
            standby_pin_state_bit    <= port_zero_pkg::RST_STBY;
            comparator_control_a     <= port_zero_pkg::RST_CMP;
            comparator_control_b     <= port_zero_pkg::RST_CMP;
        end else if (wr_ok) begin
            if (wr_sel_data) port_data_latch <= w_data;
            if (wr_sel_dir)  port_direction <= w_data;
            if (wr_sel_pull) port_pullup_enable <= w_data;
            if (wr_sel_aidr) analog_input_disable_low <= w_data;
            if (wr_sel_stby) standby_pin_state_bit <= w_data[port_zero_pkg::STBY_PIN_STATE_BIT];
            if (wr_sel_cmpa) comparator_control_a <= w_data[1:0];
            if (wr_sel_cmpb) comparator_control_b <= w_data[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel.

    logic            ar_fire;
    logic [PINS-1:0] latch_view;
    logic [PINS-1:0] data_view;
    logic [7:0]      rd_value;
    logic            rd_hit;

    assign arready    = !rvalid;
    assign ar_fire    = arvalid && arready;
    // Only plain port outputs read back the latch; all else reads the pin.
    assign latch_view = port_direction & ~periph_oe;
    assign data_view  = (latch_view & port_data_latch)
                      | (~latch_view & port_digital_in);
    assign rd_hit     = (araddr == port_zero_pkg::OFF_DATA)
                     || (araddr == port_zero_pkg::OFF_DATA_RMW)
                     || (araddr == port_zero_pkg::OFF_DIR)
                     || (araddr == port_zero_pkg::OFF_PULL)
                     || (araddr == port_zero_pkg::OFF_AIDR)
                     || (araddr == port_zero_pkg::OFF_STBY)
                     || (araddr == port_zero_pkg::OFF_CMPA)
                     || (araddr == port_zero_pkg::OFF_CMPB);
    assign rd_value =
        (araddr == port_zero_pkg::OFF_DATA)     ? 8'(data_view) :
        (araddr == port_zero_pkg::OFF_DATA_RMW) ? 8'(port_data_latch) :
        (araddr == port_zero_pkg::OFF_DIR)      ? 8'(port_direction) :
        (araddr == port_zero_pkg::OFF_PULL)     ? 8'(port_pullup_enable) :
        (araddr == port_zero_pkg::OFF_AIDR)     ? 8'(analog_input_disable_low) :
        (araddr == port_zero_pkg::OFF_STBY)     ? {7'h00, standby_pin_state_bit} :
        (araddr == port_zero_pkg::OFF_CMPA)     ? {6'h00, comparator_control_a} :
        (araddr == port_zero_pkg::OFF_CMPB)     ? {6'h00, comparator_control_b} :
        8'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= port_zero_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            rvalid <= 1'b1;
            rdata  <= {24'h000000, rd_value};
            rresp  <= rd_hit ? port_zero_pkg::RESP_OKAY : port_zero_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions and covers.

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_out_latch;
        1'b1 |=> ((pin_out ^ $past(port_data_latch)) & $past(latch_view)) == '0;
    endproperty
    a_out_latch: assert property (p_out_latch) else $error("output pin lost latch");

    property p_in_float;
        1'b1 |=> (pin_oe & $past(~port_direction & ~periph_oe)) == '0;
    endproperty
    a_in_float: assert property (p_in_float) else $error("input pin driven");

    property p_write_latch;
        (wr_ok && wr_sel_data) |=> port_data_latch == $past(w_data) ##1
            ((pin_out ^ port_data_latch) & $past(latch_view)) == '0;
    endproperty
    a_write_latch: assert property (p_write_latch) else $error("latch write lost");

    property p_read_out;
        (ar_fire && araddr == port_zero_pkg::OFF_DATA) |=>
            ((rdata[PINS-1:0] ^ $past(port_data_latch)) & $past(latch_view)) == '0;
    endproperty
    a_read_out: assert property (p_read_out) else $error("output read wrong");

    property p_read_rmw;
        (ar_fire && araddr == port_zero_pkg::OFF_DATA_RMW) |=>
            rdata[PINS-1:0] == $past(port_data_latch) && rvalid;
    endproperty
    a_read_rmw: assert property (p_read_rmw) else $error("rmw read wrong");

    property p_read_periph;
        (ar_fire && araddr == port_zero_pkg::OFF_DATA) |=>
            ((rdata[PINS-1:0] ^ $past(port_digital_in)) & $past(periph_oe)) == '0;
    endproperty
    a_read_periph: assert property (p_read_periph) else $error("periph read wrong");

    property p_iso_float;
        iso |=> pin_oe == '0;
    endproperty
    a_iso_float: assert property (p_iso_float) else $error("pin driven in isolation");

    property p_iso_irq;
        iso |-> ((ext_irq_level ^ pin_level) & ext_irq_enable) == '0
             && (port_digital_in & ~ext_irq_enable) == '0;
    endproperty
    a_iso_irq: assert property (p_iso_irq) else $error("isolation gating wrong");

    property p_pull_low;
        (pin_pullup & pin_oe & ~pin_out) == '0;
    endproperty
    a_pull_low: assert property (p_pull_low) else $error("pull-up on low output");

    property p_cmp_neg;
        (cmp_n_en & ~cmp_p_en) == 2'h0;
    endproperty
    a_cmp_neg: assert property (p_cmp_neg) else $error("negative path without enable");

    property p_reset_state;
        @(posedge aclk) $rose(aresetn) |-> port_direction == '0 && analog_input_disable_low == '0;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

    property p_aidr_block;
        (port_digital_in & ~analog_input_disable_low) == '0;
    endproperty
    a_aidr_block: assert property (p_aidr_block) else $error("analog pin read digitally");

    property p_write_resp;
        wr_fire |=> bvalid;
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("no write response");

    c_write_data: cover property (wr_ok && wr_sel_data);
    c_read_rmw:   cover property (ar_fire && araddr == port_zero_pkg::OFF_DATA_RMW);
    c_isolation:  cover property (iso && (ext_irq_enable != '0));
    c_periph:     cover property (periph_oe != '0 && pin_oe != '0);

endmodule // port_zero_gpio

// ===== port_zero_pins.sv
// Model of the board pins around the eight-pin port.
`timescale 1ns/1ns
module port_zero_pins (
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pin_pullup,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic [7:0]      pin_in
);
    ////////////////////////////////////////////////////////////////////////////////
    // A pin nobody holds wanders, so the bench never predicts its level.
    logic flt = 1'b0;
    always #7 flt = ~flt;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                        pin_pullup[i] ? 1'b1 : flt;
        end
    end
endmodule // port_zero_pins

// ===== tb_eight_bit_io_port_zero.sv
// Self-checking bench for the eight-pin port against a reference model.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_count++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb_eight_bit_io_port_zero;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'h1;
    logic        awready, wready, bvalid, arready, rvalid, standby_mode = 1'b0;
    logic [1:0]  bresp, rresp, cmp_p_en, cmp_n_en, r;
    logic [7:0]  pin_in, pin_out, pin_oe, pin_pullup, ext_irq_level, port_digital_in;
    logic [7:0]  analog_path_en, periph_oe = 8'h00, periph_out = 8'h00, ext_irq_enable = 8'h00;
    logic [7:0]  ext_en = 8'hff, ext_val = 8'h00, s = 8'h32;
    logic [7:0]  latch, dir, pull, aidr, poe, pout, een, ev, irqen, oe, out, lv, dig, m;
    logic [31:0] d;
    logic        iso = 1'b0;
    int          err_count = 0, num_checks = 0;

    port_zero_gpio uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .periph_oe(periph_oe), .periph_out(periph_out), .standby_mode(standby_mode),
        .ext_irq_enable(ext_irq_enable), .ext_irq_level(ext_irq_level),
        .port_digital_in(port_digital_in), .analog_path_en(analog_path_en),
        .cmp_p_en(cmp_p_en), .cmp_n_en(cmp_n_en));
    port_zero_pins pins (.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #5 aclk = ~aclk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Ready is sampled on the falling edge; it cannot move before the next rising edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] rs);
        logic ah, wh, bh;
        ah = 1'b0;
        wh = 1'b0;
        bh = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (awvalid || wvalid) begin
            @(negedge aclk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            #0;
        end
        while (!bh) begin
            @(negedge aclk);
            bh = bvalid;
            rs = bresp;
            @(posedge aclk);
            if (bh) bready <= 1'b0;
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic hs;
        hs = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!hs) begin
            @(negedge aclk);
            hs = arvalid && arready;
            @(posedge aclk);
            if (hs) arvalid <= 1'b0;
        end
        hs = 1'b0;
        while (!hs) begin
            @(negedge aclk);
            hs = rvalid;
            v = rdata;
            rs = rresp;
            @(posedge aclk);
            if (hs) rready <= 1'b0;
        end
    endtask
    // The pin path has a synchroniser and a filter stage, so give it room to settle.
    task automatic settle;
        repeat (8) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic check_all;
        oe = iso ? 8'h00 : (dir | poe);
        out = (poe & pout) | (~poe & latch);
        lv = (oe & out) | (~oe & een & ev) | (~oe & ~een & pull);
        dig = lv & aidr & (iso ? irqen : 8'hff);
        m = dir & ~poe;
        `CHK("pin_oe", oe, pin_oe)
        `CHK("pin_out", out & oe, pin_out & oe)
        `CHK("pin_pullup", pull & ~(oe & ~out), pin_pullup)
        `CHK("ext_irq_level", iso ? (lv & irqen) : lv, ext_irq_level)
        `CHK("port_digital_in", dig, port_digital_in)
        `CHK("analog_path_en", ~aidr, analog_path_en)
        rd(port_zero_pkg::OFF_DATA, d, r);
        `CHK("data read", {24'h0, (latch & m) | (dig & ~m)}, d)
        rd(port_zero_pkg::OFF_DATA_RMW, d, r);
        `CHK("rmw read", {24'h0, latch}, d)
        rd(port_zero_pkg::OFF_PULL, d, r);
        `CHK("pullup read", {24'h0, pull}, d)
        rd(port_zero_pkg::OFF_AIDR, d, r);
        `CHK("aidr read", {24'h0, aidr}, d)
    endtask

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(port_zero_pkg::OFF_DIR, d, r);
        `CHK("dir reset", 32'h0, d)
        rd(port_zero_pkg::OFF_AIDR, d, r);
        `CHK("aidr reset", 32'h0, d)
        `CHK("path reset", 8'hff, analog_path_en)
        `CHK("oe reset", 8'h00, pin_oe)
        wr(8'h20, 8'h5a, r);
        `CHK("unmapped bresp", port_zero_pkg::RESP_SLVERR, r)
        rd(8'h22, d, r);
        `CHK("unmapped rresp", port_zero_pkg::RESP_SLVERR, r)
        `CHK("unmapped rdata", 32'h0, d)
        for (int i = 0; i < 24; i++) begin
            s = lfsr(s); latch = s;
            s = lfsr(s); dir = s;
            s = lfsr(s); pull = s;
            s = lfsr(s); aidr = s;
            s = lfsr(s); poe = i[0] ? s : 8'h00;
            s = lfsr(s); pout = s;
            s = lfsr(s); een = ~pull | s;
            s = lfsr(s); ev = s;
            wr(port_zero_pkg::OFF_DIR, dir, r);
            wr(port_zero_pkg::OFF_PULL, pull, r);
            wr(port_zero_pkg::OFF_AIDR, aidr, r);
            wr(i[1] ? port_zero_pkg::OFF_DATA : port_zero_pkg::OFF_DATA_RMW, latch, r);
            `CHK("data bresp", port_zero_pkg::RESP_OKAY, r)
            periph_oe <= poe;
            periph_out <= pout;
            ext_en <= een;
            ext_val <= ev;
            ext_irq_enable <= s;
            settle;
            check_all;
        end
        s = lfsr(s);
        irqen = s & ~dir & ~poe;
        ext_irq_enable <= irqen;
        standby_mode <= 1'b1;
        wr(port_zero_pkg::OFF_STBY, 8'h01, r);
        iso = 1'b1;
        settle;
        check_all;
        wr(port_zero_pkg::OFF_STBY, 8'h00, r);
        iso = 1'b0;
        settle;
        check_all;
        wr(port_zero_pkg::OFF_DIR, 8'h00, r);
        wr(port_zero_pkg::OFF_AIDR, 8'h00, r);
        wr(port_zero_pkg::OFF_PULL, 8'h00, r);
        periph_oe <= 8'h00;
        wstrb <= 4'h0;
        wr(port_zero_pkg::OFF_PULL, 8'hff, r);
        wstrb <= 4'h1;
        rd(port_zero_pkg::OFF_PULL, d, r);
        `CHK("masked write", 32'h0, d)
        `CHK("analog path", 8'hff, analog_path_en)
        for (int c = 0; c < 4; c++) begin
            wr(port_zero_pkg::OFF_CMPA, c[7:0], r);
            wr(port_zero_pkg::OFF_CMPB, 8'h03 - c[7:0], r);
            settle;
            `CHK("cmp_p_en", {c[0] == 1'b1, c[0] == 1'b0}, cmp_p_en)
            `CHK("cmp_n_en", {c == 3, c == 0}, cmp_n_en)
        end
        stop_test;
    end
    initial begin
        #100000;
        err_count++;
        stop_test;
    end
endmodule // tb_eight_bit_io_port_zero
